// ==== logic/cvx_pkg.sv ====
// constants and types shared by the conversion and system instruction executor
package cvx_pkg;
	// ==========================================
	// instruction codes (10-bit words)
	localparam logic [9:0] OP_READ_CONV_RESULT_HIGH = 10'h279;
	localparam logic [9:0] OP_READ_CONV_RESULT_LOW = 10'h249;
	localparam logic [9:0] OP_WRITE_COMPARE_VALUE = 10'h239;
	localparam logic [9:0] OP_READ_CONV_CONTROL = 10'h244;
	localparam logic [9:0] OP_WRITE_CONV_CONTROL = 10'h204;
	localparam logic [9:0] OP_START_CONVERSION = 10'h29F;
	localparam logic [9:0] OP_SKIP_ON_CONVERSION_DONE = 10'h287;
	localparam logic [9:0] OP_NO_OPERATION = 10'h000;
	localparam logic [9:0] OP_ENTER_BACKUP = 10'h002;
	localparam logic [9:0] OP_ARM_BACKUP_ENTRY = 10'h05B;
	localparam logic [9:0] OP_SKIP_IF_BACKUP_FLAG = 10'h003;
	localparam logic [9:0] OP_ARM_WATCHDOG_STOP = 10'h29C;
	localparam logic [9:0] OP_WATCHDOG_FLAG_CLEAR_SKIP = 10'h2A0;
	localparam logic [9:0] OP_SOFTWARE_SYSTEM_RESET = 10'h001;
	localparam logic [9:0] OP_CLEAR_UPPER_REF_FLAG = 10'h058;
	localparam logic [9:0] OP_SET_UPPER_REF_FLAG = 10'h059;
	localparam logic [9:0] OP_ARM_BACKUP_VOLTAGE_MONITOR = 10'h293;
	// ==========================================
	// register offsets (byte addresses)
	localparam logic [7:0] ADDR_INSTR = 8'h00;
	localparam logic [7:0] ADDR_ACC = 8'h04;
	localparam logic [7:0] ADDR_ICR2 = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0C;
	// ==========================================
	// field positions
	localparam int MODE_BIT = 3;
	localparam int DONE_SKIP_DISABLE_BIT = 2;
	localparam int ACC_B_LSB = 4;
	localparam int ST_CMP_LSB = 4;
	localparam int ST_DONE = 12;
	localparam int ST_BACKUP_FLAG = 13;
	localparam int ST_WATCHDOG_FLAG_ONE = 14;
	localparam int ST_UPPER_REF = 15;
	localparam int ST_IN_BACKUP = 16;
	localparam int ST_WDT_STOPPED = 17;
	localparam int ST_VMON_ARMED = 18;
	// ==========================================
	// reset values
	localparam logic [3:0] RST_NIBBLE = 4'h0;
	localparam logic [7:0] RST_COMPARE = 8'h00;
	localparam logic [9:0] RST_OPCODE = 10'h000;
	// ==========================================
	// one-cycle events toward the cpu core and the converter
	typedef struct packed {
		logic pc_advance;
		logic skip_next;
		logic start_adc;
		logic start_compare;
		logic system_reset;
	} exec_evt_t;
	typedef enum logic [1:0] {
		ST_RUN = 2'b01,
		ST_BACKUP = 2'b10
	} power_state_t;
endpackage

// ==== logic/conversion_and_system_instr_exec.sv ====
// executor for converter and system instructions, apb register access
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/1ps

module conversion_and_system_instr_exec #(
	parameter bit HAS_VOLTAGE_MONITOR = 1'b1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [9:0] conv_result,
	input wire logic conv_done,
	input wire logic backup_wake,
	input wire logic watchdog_overflow,
	output cvx_pkg::exec_evt_t exec_evt,
	output logic watchdog_stopped,
	output logic upper_bit_reference_enable,
	output logic voltage_detect_enable,
	output logic functions_stopped
);
	import cvx_pkg::*;

	// ==========================================
	// state
	logic [3:0] acc_a_q, acc_a_d;
	logic [3:0] acc_b_q, acc_b_d;
	logic [7:0] compare_q, compare_d;
	logic [3:0] converter_control_reg_q, converter_control_reg_d;
	logic [3:0] interrupt_control_reg_two_q, interrupt_control_reg_two_d;
	logic conversion_done_flag_q, conversion_done_flag_d;
	logic backup_flag_q, backup_flag_d;
	logic watchdog_flag_one_q, watchdog_flag_one_d;
	logic upper_ref_q, upper_ref_d;
	logic wdt_stopped_q, wdt_stopped_d;
	logic vmon_armed_q, vmon_armed_d;
	logic backup_armed_q, backup_armed_d;
	logic wdt_armed_q, wdt_armed_d;
	logic [9:0] last_op_q, last_op_d;
	power_state_t pstate_q, pstate_d;
	exec_evt_t evt_q, evt_d;

	logic acc_wr;
	logic instr_wr;
	logic exec;
	logic mode_cmp;
	logic [9:0] op;
	logic [31:0] rdata;
	logic mapped;

	// ==========================================
	// apb decode: zero wait states, unmapped address answers with pslverr
	assign pready = 1'b1;
	assign mapped = (paddr == ADDR_INSTR) || (paddr == ADDR_ACC) || (paddr == ADDR_ICR2) || (paddr == ADDR_STATUS);
	assign pslverr = psel && penable && !mapped;
	assign instr_wr = psel && penable && pwrite && (paddr == ADDR_INSTR);
	assign acc_wr = psel && penable && pwrite && (paddr == ADDR_ACC);
	assign op = pwdata[9:0];
	// in backup nothing executes, so the core cannot leave it by itself
	assign exec = instr_wr && (pstate_q == ST_RUN);
	assign mode_cmp = converter_control_reg_q[MODE_BIT];

	always_comb begin
		rdata = 32'h0000_0000;
		unique case (paddr)
			ADDR_INSTR: rdata[9:0] = last_op_q;
			ADDR_ACC: rdata[7:0] = {acc_b_q, acc_a_q};
			ADDR_ICR2: rdata[3:0] = interrupt_control_reg_two_q;
			ADDR_STATUS: begin
				rdata[3:0] = converter_control_reg_q;
				rdata[ST_CMP_LSB +: 8] = compare_q;
				rdata[ST_DONE] = conversion_done_flag_q;
				rdata[ST_BACKUP_FLAG] = backup_flag_q;
				rdata[ST_WATCHDOG_FLAG_ONE] = watchdog_flag_one_q;
				rdata[ST_UPPER_REF] = upper_ref_q;
				rdata[ST_IN_BACKUP] = (pstate_q == ST_BACKUP);
				rdata[ST_WDT_STOPPED] = wdt_stopped_q;
				rdata[ST_VMON_ARMED] = vmon_armed_q;
			end
			default: rdata = 32'h0000_0000;
		endcase
	end
	assign prdata = (psel && !pwrite && mapped) ? rdata : 32'h0000_0000;

	// ==========================================
	// instruction execution
	always_comb begin
		acc_a_d = acc_a_q;
		acc_b_d = acc_b_q;
		compare_d = compare_q;
		converter_control_reg_d = converter_control_reg_q;
		interrupt_control_reg_two_d = interrupt_control_reg_two_q;
		conversion_done_flag_d = conversion_done_flag_q;
		backup_flag_d = backup_flag_q;
		watchdog_flag_one_d = watchdog_flag_one_q;
		upper_ref_d = upper_ref_q;
		wdt_stopped_d = wdt_stopped_q;
		vmon_armed_d = vmon_armed_q;
		backup_armed_d = backup_armed_q;
		wdt_armed_d = wdt_armed_q;
		last_op_d = last_op_q;
		pstate_d = pstate_q;
		evt_d = '0;
		if (acc_wr) begin
			acc_a_d = pwdata[3:0];
			acc_b_d = pwdata[ACC_B_LSB +: 4];
		end
		if (psel && penable && pwrite && (paddr == ADDR_ICR2)) begin
			interrupt_control_reg_two_d = pwdata[3:0];
		end
		if (exec) begin
			last_op_d = op;
			evt_d.pc_advance = 1'b1;
			// arming lasts for exactly one following instruction
			backup_armed_d = (op == OP_ARM_BACKUP_ENTRY);
			wdt_armed_d = (op == OP_ARM_WATCHDOG_STOP);
			unique case (op)
				OP_READ_CONV_RESULT_HIGH: begin
					if (mode_cmp) begin
						acc_b_d = compare_q[7:4];
						acc_a_d = compare_q[3:0];
					end else begin
						acc_b_d = conv_result[9:6];
						acc_a_d = conv_result[5:2];
					end
				end
				OP_READ_CONV_RESULT_LOW: acc_a_d = {conv_result[1:0], 2'b00};
				OP_WRITE_COMPARE_VALUE: begin
					if (mode_cmp) begin
						compare_d = {acc_b_q, acc_a_q};
					end
					// adc mode falls through as a plain counter advance
				end
				OP_READ_CONV_CONTROL: acc_a_d = converter_control_reg_q;
				OP_WRITE_CONV_CONTROL: converter_control_reg_d = acc_a_q;
				OP_START_CONVERSION: begin
					conversion_done_flag_d = 1'b0;
					evt_d.start_adc = !mode_cmp;
					evt_d.start_compare = mode_cmp;
				end
				OP_SKIP_ON_CONVERSION_DONE: begin
					if (!interrupt_control_reg_two_q[DONE_SKIP_DISABLE_BIT] && conversion_done_flag_q) begin
						evt_d.skip_next = 1'b1;
						conversion_done_flag_d = 1'b0;
					end
					// disabled: flag and flow untouched
				end
				OP_ENTER_BACKUP: begin
					if (backup_armed_q) begin
						pstate_d = ST_BACKUP;
					end
					// unarmed entry only advances the counter
				end
				OP_SKIP_IF_BACKUP_FLAG: evt_d.skip_next = backup_flag_q;
				OP_WATCHDOG_FLAG_CLEAR_SKIP: begin
					evt_d.skip_next = watchdog_flag_one_q;
					watchdog_flag_one_d = 1'b0;
					if (wdt_armed_q) begin
						wdt_stopped_d = 1'b1;
					end
				end
				OP_SOFTWARE_SYSTEM_RESET: evt_d.system_reset = 1'b1;
				OP_CLEAR_UPPER_REF_FLAG: upper_ref_d = 1'b0;
				OP_SET_UPPER_REF_FLAG: upper_ref_d = 1'b1;
				OP_ARM_BACKUP_VOLTAGE_MONITOR: vmon_armed_d = HAS_VOLTAGE_MONITOR;
				default: begin
				end
			endcase
		end
		// hardware events win over a clear in the same cycle
		if (conv_done) begin
			conversion_done_flag_d = 1'b1;
		end
		if (watchdog_overflow && !wdt_stopped_q) begin
			watchdog_flag_one_d = 1'b1;
		end
		if ((pstate_q == ST_BACKUP) && backup_wake) begin
			pstate_d = ST_RUN;
			backup_flag_d = 1'b1;
		end
	end

	// software reset reloads every register at the edge after the pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_a_q <= RST_NIBBLE;
			acc_b_q <= RST_NIBBLE;
			compare_q <= RST_COMPARE;
			converter_control_reg_q <= RST_NIBBLE;
			interrupt_control_reg_two_q <= RST_NIBBLE;
			conversion_done_flag_q <= 1'b0;
			backup_flag_q <= 1'b0;
			watchdog_flag_one_q <= 1'b0;
			upper_ref_q <= 1'b0;
			wdt_stopped_q <= 1'b0;
			vmon_armed_q <= 1'b0;
			backup_armed_q <= 1'b0;
			wdt_armed_q <= 1'b0;
			last_op_q <= RST_OPCODE;
			pstate_q <= ST_RUN;
			evt_q <= '0;
		end else if (evt_q.system_reset) begin
			acc_a_q <= RST_NIBBLE;
			acc_b_q <= RST_NIBBLE;
			compare_q <= RST_COMPARE;
			converter_control_reg_q <= RST_NIBBLE;
			interrupt_control_reg_two_q <= RST_NIBBLE;
			conversion_done_flag_q <= 1'b0;
			backup_flag_q <= 1'b0;
			watchdog_flag_one_q <= 1'b0;
			upper_ref_q <= 1'b0;
			wdt_stopped_q <= 1'b0;
			vmon_armed_q <= 1'b0;
			backup_armed_q <= 1'b0;
			wdt_armed_q <= 1'b0;
			last_op_q <= RST_OPCODE;
			pstate_q <= ST_RUN;
			evt_q <= '0;
		end else begin
			acc_a_q <= acc_a_d;
			acc_b_q <= acc_b_d;
			compare_q <= compare_d;
			converter_control_reg_q <= converter_control_reg_d;
			interrupt_control_reg_two_q <= interrupt_control_reg_two_d;
			conversion_done_flag_q <= conversion_done_flag_d;
			backup_flag_q <= backup_flag_d;
			watchdog_flag_one_q <= watchdog_flag_one_d;
			upper_ref_q <= upper_ref_d;
			wdt_stopped_q <= wdt_stopped_d;
			vmon_armed_q <= vmon_armed_d;
			backup_armed_q <= backup_armed_d;
			wdt_armed_q <= wdt_armed_d;
			last_op_q <= last_op_d;
			pstate_q <= pstate_d;
			evt_q <= evt_d;
		end
	end

	assign exec_evt = evt_q;
	assign watchdog_stopped = wdt_stopped_q;
	assign upper_bit_reference_enable = upper_ref_q;
	assign functions_stopped = (pstate_q == ST_BACKUP);
	assign voltage_detect_enable = vmon_armed_q && (pstate_q == ST_BACKUP);

	// ==========================================
	// assertions
	property p_high_adc;
		@(posedge pclk) disable iff (!presetn)
		exec && op == OP_READ_CONV_RESULT_HIGH && !mode_cmp && !evt_q.system_reset
		|=> acc_b_q == $past(conv_result[9:6]) && acc_a_q == $past(conv_result[5:2]);
	endproperty
	a_high_adc: assert property (p_high_adc) else $error("adc high read wrong");

	property p_high_cmp;
		@(posedge pclk) disable iff (!presetn)
		exec && op == OP_READ_CONV_RESULT_HIGH && mode_cmp && !evt_q.system_reset
		|=> {acc_b_q, acc_a_q} == $past(compare_q);
	endproperty
	a_high_cmp: assert property (p_high_cmp) else $error("comparator read wrong");

	property p_low;
		@(posedge pclk) disable iff (!presetn)
		exec && op == OP_READ_CONV_RESULT_LOW && !evt_q.system_reset
		|=> acc_a_q[3:2] == $past(conv_result[1:0]) && acc_a_q[0] == 1'b0;
	endproperty
	a_low: assert property (p_low) else $error("low read wrong");

	property p_cmp_write;
		@(posedge pclk) disable iff (!presetn)
		exec && op == OP_WRITE_COMPARE_VALUE && !evt_q.system_reset
		|=> (mode_cmp ? compare_q == {$past(acc_b_q), $past(acc_a_q)} : $stable(compare_q)) ##1 $stable(compare_q)
			or (exec && op == OP_WRITE_COMPARE_VALUE) or evt_q.system_reset;
	endproperty
	a_cmp_write: assert property (p_cmp_write) else $error("compare write wrong");

	property p_start;
		@(posedge pclk) disable iff (!presetn)
		exec && op == OP_START_CONVERSION && !conv_done && !evt_q.system_reset
		|=> !conversion_done_flag_q && exec_evt.start_adc == !$past(mode_cmp) && exec_evt.start_compare == $past(mode_cmp);
	endproperty
	a_start: assert property (p_start) else $error("start did not clear done flag");

	property p_skip_done;
		@(posedge pclk) disable iff (!presetn)
		exec && op == OP_SKIP_ON_CONVERSION_DONE && !evt_q.system_reset
		|=> exec_evt.skip_next == ($past(conversion_done_flag_q) && !$past(interrupt_control_reg_two_q[2]));
	endproperty
	a_skip_done: assert property (p_skip_done) else $error("done skip wrong");

	property p_backup;
		@(posedge pclk) disable iff (!presetn)
		exec && op == OP_ENTER_BACKUP && !evt_q.system_reset
		|=> functions_stopped == $past(backup_armed_q);
	endproperty
	a_backup: assert property (p_backup) else $error("backup entry wrong");

	property p_wdt_stop;
		@(posedge pclk) disable iff (!presetn)
		!wdt_stopped_q && !evt_q.system_reset ##1 wdt_stopped_q
		|-> $past(exec) && $past(op) == OP_WATCHDOG_FLAG_CLEAR_SKIP && $past(wdt_armed_q);
	endproperty
	a_wdt_stop: assert property (p_wdt_stop) else $error("watchdog stopped without arming");

	property p_upper;
		@(posedge pclk) disable iff (!presetn)
		exec && (op == OP_SET_UPPER_REF_FLAG || op == OP_CLEAR_UPPER_REF_FLAG) && !evt_q.system_reset
		|=> upper_bit_reference_enable == ($past(op) == OP_SET_UPPER_REF_FLAG) ##1 1'b1;
	endproperty
	a_upper: assert property (p_upper) else $error("upper reference flag wrong");

	property p_nop;
		@(posedge pclk) disable iff (!presetn)
		exec && op == OP_NO_OPERATION && !evt_q.system_reset
		|=> $stable({acc_b_q, acc_a_q, compare_q, converter_control_reg_q, upper_ref_q, wdt_stopped_q})
			&& !functions_stopped && exec_evt == exec_evt_t'(5'h10);
	endproperty
	a_nop: assert property (p_nop) else $error("no-op changed state");

	property p_ctrl_write;
		@(posedge pclk) disable iff (!presetn)
		exec && op == OP_WRITE_CONV_CONTROL && !evt_q.system_reset
		|=> converter_control_reg_q == $past(acc_a_q);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("control write wrong");

	property p_ctrl_read;
		@(posedge pclk) disable iff (!presetn)
		exec && op == OP_READ_CONV_CONTROL && !evt_q.system_reset
		|=> acc_a_q == $past(converter_control_reg_q) && acc_b_q == $past(acc_b_q);
	endproperty
	a_ctrl_read: assert property (p_ctrl_read) else $error("control read wrong");

	property p_skip_backup;
		@(posedge pclk) disable iff (!presetn)
		exec && op == OP_SKIP_IF_BACKUP_FLAG && !evt_q.system_reset
		|=> exec_evt.skip_next == $past(backup_flag_q) && $stable(backup_flag_q);
	endproperty
	a_skip_backup: assert property (p_skip_backup) else $error("backup flag skip wrong");

	property p_wdf_skip;
		@(posedge pclk) disable iff (!presetn)
		exec && op == OP_WATCHDOG_FLAG_CLEAR_SKIP && !evt_q.system_reset && !watchdog_overflow
		|=> exec_evt.skip_next == $past(watchdog_flag_one_q) && !watchdog_flag_one_q;
	endproperty
	a_wdf_skip: assert property (p_wdf_skip) else $error("watchdog flag skip wrong");

	property p_soft_reset;
		@(posedge pclk) disable iff (!presetn)
		evt_q.system_reset
		|=> {acc_b_q, acc_a_q} == {RST_NIBBLE, RST_NIBBLE} && compare_q == RST_COMPARE && exec_evt == exec_evt_t'(5'h00)
			&& !functions_stopped && !watchdog_stopped && !upper_bit_reference_enable;
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("software reset incomplete");

	property p_vmon;
		@(posedge pclk) disable iff (!presetn)
		exec && op == OP_ARM_BACKUP_VOLTAGE_MONITOR && !evt_q.system_reset
		|=> vmon_armed_q == HAS_VOLTAGE_MONITOR && !voltage_detect_enable;
	endproperty
	a_vmon: assert property (p_vmon) else $error("voltage monitor arming wrong");
endmodule

// ==== testbench/tb_conversion_and_system_instr_exec.sv ====
// self-checking bench for the converter and system instruction executor
`timescale 1ns/1ps
module tb_conversion_and_system_instr_exec;
	import cvx_pkg::*;
	// ==========================================
	// stimulus and design
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [9:0] conv_result;
	logic conv_done, backup_wake, watchdog_overflow;
	exec_evt_t exec_evt;
	logic watchdog_stopped, upper_bit_reference_enable, voltage_detect_enable, functions_stopped;
	int miscompares = 0;
	int num_checks = 0;
	localparam logic [31:0] M_DONE = 32'h1 << ST_DONE;
	localparam logic [31:0] M_WDF = 32'h1 << ST_WATCHDOG_FLAG_ONE;
	localparam logic [31:0] M_BK = (32'h1 << ST_BACKUP_FLAG) | (32'h1 << ST_IN_BACKUP);
	conversion_and_system_instr_exec i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.conv_result(conv_result), .conv_done(conv_done), .backup_wake(backup_wake),
		.watchdog_overflow(watchdog_overflow), .exec_evt(exec_evt), .watchdog_stopped(watchdog_stopped),
		.upper_bit_reference_enable(upper_bit_reference_enable), .voltage_detect_enable(voltage_detect_enable),
		.functions_stopped(functions_stopped));
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	// ==========================================
	// tasks
	task automatic finish_test();
		$display("checks %0d, mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	// request held from setup until the edge that sees pready high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no local limit: a slave that never answers is caught by the watchdog
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		chk(name, exp, q & m);
		chk("pslverr", 32'h0, {31'h0, e});
	endtask
	// events stand for the one cycle after the taking edge
	task automatic exec(input logic [9:0] op, input logic [4:0] ev);
		wr(ADDR_INSTR, {22'h0, op});
		#1;
		chk("exec_evt", {27'h0, ev}, {27'h0, exec_evt});
	endtask
	task automatic outs(input logic [3:0] exp);
		#1;
		chk("outputs", {28'h0, exp}, {28'h0, functions_stopped, watchdog_stopped, upper_bit_reference_enable,
			voltage_detect_enable});
	endtask
	// ==========================================
	// tests
	initial begin
		repeat (5000) @(posedge pclk);
		miscompares++;
		finish_test();
	end
	initial begin
		logic [31:0] q;
		logic e;
		presetn = 1'b0;
		{psel, penable, pwrite, conv_done, backup_wake, watchdog_overflow} = 6'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		conv_result = 10'h2B5;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		outs(4'h0);
		rchk("status", ADDR_STATUS, 32'hFFFFFFFF, 32'h0);
		apb(1'b0, 8'h10, 32'h0, q, e);
		chk("unmapped", 32'h1, {q[30:0], e});
		exec(OP_READ_CONV_RESULT_HIGH, 5'h10);
		rchk("acc", ADDR_ACC, 32'hFF, 32'hAD);
		exec(OP_READ_CONV_RESULT_LOW, 5'h10);
		rchk("acc", ADDR_ACC, 32'hFF, 32'hA4);
		wr(ADDR_ACC, 32'h5C);
		exec(OP_WRITE_COMPARE_VALUE, 5'h10);
		rchk("cmp", ADDR_STATUS, 32'hFF0, 32'h0);
		rchk("acc", ADDR_ACC, 32'hFF, 32'h5C);
		wr(ADDR_ACC, 32'h08);
		exec(OP_WRITE_CONV_CONTROL, 5'h10);
		rchk("ctrl", ADDR_STATUS, 32'hF, 32'h8);
		wr(ADDR_ACC, 32'h5C);
		exec(OP_WRITE_COMPARE_VALUE, 5'h10);
		rchk("cmp", ADDR_STATUS, 32'hFF0, 32'h5C0);
		wr(ADDR_ACC, 32'h00);
		exec(OP_READ_CONV_RESULT_HIGH, 5'h10);
		rchk("acc", ADDR_ACC, 32'hFF, 32'h5C);
		wr(ADDR_ACC, 32'h00);
		exec(OP_READ_CONV_CONTROL, 5'h10);
		rchk("acc", ADDR_ACC, 32'hFF, 32'h08);
		@(posedge pclk) conv_done <= 1'b1;
		@(posedge pclk) conv_done <= 1'b0;
		rchk("done", ADDR_STATUS, M_DONE, M_DONE);
		exec(OP_START_CONVERSION, 5'h12);
		rchk("done", ADDR_STATUS, M_DONE, 32'h0);
		wr(ADDR_ACC, 32'h00);
		exec(OP_WRITE_CONV_CONTROL, 5'h10);
		exec(OP_START_CONVERSION, 5'h14);
		wr(ADDR_ICR2, 32'h0);
		@(posedge pclk) conv_done <= 1'b1;
		@(posedge pclk) conv_done <= 1'b0;
		exec(OP_SKIP_ON_CONVERSION_DONE, 5'h18);
		rchk("done", ADDR_STATUS, M_DONE, 32'h0);
		exec(OP_SKIP_ON_CONVERSION_DONE, 5'h10);
		wr(ADDR_ICR2, 32'h4);
		rchk("icr2", ADDR_ICR2, 32'hF, 32'h4);
		@(posedge pclk) conv_done <= 1'b1;
		@(posedge pclk) conv_done <= 1'b0;
		exec(OP_SKIP_ON_CONVERSION_DONE, 5'h10);
		rchk("done", ADDR_STATUS, M_DONE, M_DONE);
		exec(OP_NO_OPERATION, 5'h10);
		rchk("status", ADDR_STATUS, 32'hFFFFFFFF, 32'h15C0);
		rchk("acc", ADDR_ACC, 32'hFF, 32'h0);
		exec(OP_SET_UPPER_REF_FLAG, 5'h10);
		outs(4'h2);
		exec(OP_CLEAR_UPPER_REF_FLAG, 5'h10);
		outs(4'h0);
		@(posedge pclk) watchdog_overflow <= 1'b1;
		@(posedge pclk) watchdog_overflow <= 1'b0;
		exec(OP_WATCHDOG_FLAG_CLEAR_SKIP, 5'h18);
		rchk("watchdog_flag_one", ADDR_STATUS, M_WDF, 32'h0);
		exec(OP_WATCHDOG_FLAG_CLEAR_SKIP, 5'h10);
		exec(OP_ARM_WATCHDOG_STOP, 5'h10);
		exec(OP_NO_OPERATION, 5'h10);
		exec(OP_WATCHDOG_FLAG_CLEAR_SKIP, 5'h10);
		outs(4'h0);
		exec(OP_ARM_WATCHDOG_STOP, 5'h10);
		exec(OP_WATCHDOG_FLAG_CLEAR_SKIP, 5'h10);
		outs(4'h4);
		@(posedge pclk) watchdog_overflow <= 1'b1;
		@(posedge pclk) watchdog_overflow <= 1'b0;
		rchk("watchdog_flag_one", ADDR_STATUS, M_WDF, 32'h0);
		exec(OP_ENTER_BACKUP, 5'h10);
		outs(4'h4);
		exec(OP_ARM_BACKUP_ENTRY, 5'h10);
		exec(OP_NO_OPERATION, 5'h10);
		exec(OP_ENTER_BACKUP, 5'h10);
		outs(4'h4);
		exec(OP_ARM_BACKUP_VOLTAGE_MONITOR, 5'h10);
		outs(4'h4);
		exec(OP_ARM_BACKUP_ENTRY, 5'h10);
		exec(OP_ENTER_BACKUP, 5'h10);
		outs(4'hD);
		// a stopped core must not act on instructions
		exec(OP_NO_OPERATION, 5'h00);
		rchk("last_op", ADDR_INSTR, 32'h3FF, {22'h0, OP_ENTER_BACKUP});
		@(posedge pclk) backup_wake <= 1'b1;
		@(posedge pclk) backup_wake <= 1'b0;
		rchk("backup", ADDR_STATUS, M_BK, 32'h1 << ST_BACKUP_FLAG);
		exec(OP_SKIP_IF_BACKUP_FLAG, 5'h18);
		rchk("backup", ADDR_STATUS, M_BK, 32'h1 << ST_BACKUP_FLAG);
		rchk("last_op", ADDR_INSTR, 32'h3FF, {22'h0, OP_SKIP_IF_BACKUP_FLAG});
		exec(OP_SOFTWARE_SYSTEM_RESET, 5'h11);
		@(posedge pclk);
		outs(4'h0);
		rchk("status", ADDR_STATUS, 32'hFFFFFFFF, 32'h0);
		rchk("acc", ADDR_ACC, 32'hFF, 32'h0);
		exec(OP_SKIP_IF_BACKUP_FLAG, 5'h10);
		finish_test();
	end
endmodule
